// file: bench/abcu_apb_host.sv
// apb master standing in for the instruction sequencer
`timescale 1ns/100ps
`default_nettype none
module abcu_apb_host (
   input  wire logic        clk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr
);
   initial {psel, penable, pwrite, paddr, pwdata} = '0;

   // called just after a rising edge; request held until pready is seen high
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
                       output logic e);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle cycle so the next request never rewrites psel in this time step
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// file: bench/abcu_unit_sva.sv
// port-level assertions for the accumulator unit
`timescale 1ns/100ps
`default_nettype none
module abcu_unit_sva (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic [2:0] last_op;
   logic       wr_q;
   wire        wr_now = psel && penable && pwrite && pready;
   wire        setup_rd = psel && !penable && !pwrite && ce;
   // last command seen; an acc write makes later acc reads unrelated to it
   always_ff @(posedge clk) begin
      wr_q <= wr_now;
      if (!reset_n) last_op <= 3'h0;
      else if (wr_now && paddr == 12'h004) last_op <= pwdata[2:0];
      else if (wr_now && paddr == 12'h000) last_op <= 3'h0;
   end
   pready_ce_a: assert property (psel && !penable && ce |=> pready == ce) else $error("pready not ce");
   unmapped_err_a: assert property (setup_rd && paddr > 12'h010 |=> pslverr && prdata == 32'h0)
      else $error("unmapped read accepted");
   mapped_ok_a: assert property (setup_rd && paddr <= 12'h010 && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped read refused");
   cmd_zero_a: assert property (setup_rd && paddr == 12'h004 |=> prdata == 32'h0) else $error("cmd read not 0");
   flags_width_a: assert property (setup_rd && paddr == 12'h008 |=> prdata[31:5] == 27'h0)
      else $error("flags upper bits set");
   enc_width_a: assert property (setup_rd && paddr == 12'h000 && last_op == 3'h2 |=> prdata[31:5] == 27'h0)
      else $error("encode result too wide");
   dec_onehot_a: assert property (setup_rd && paddr == 12'h000 && last_op == 3'h3 |=> $onehot(prdata))
      else $error("decode not one-hot");
   irq_fall_a: assert property ($fell(irq) |-> wr_q || !$past(reset_n)) else $error("irq fell without write");
   cover property (setup_rd && last_op == 3'h3);
   cover property ($fell(irq));
   cover property (setup_rd && paddr > 12'h010);
   cover property (psel && penable && !pready);
endmodule
bind abcu_unit abcu_unit_sva i_sva (.clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// file: bench/tb_abcu_unit.sv
// self-checking bench: accumulator unit against an integer model
`timescale 1ns/100ps
`default_nettype none
module tb_abcu_unit;
   logic        clk = 1'b0;
   logic        reset_n = 1'b0;
   logic        ce = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  m_flg = 4'h0;
   logic [2:0]  m_stat = 3'h0;
   int          err_total = 0;
   int          cmp_count = 0;

   initial begin
      forever #12.5 clk = ~clk;
   end
   abcu_unit i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .irq(irq));
   abcu_apb_host i_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_host.xfer(1'b1, a, d, rd, e);
   endtask
   task automatic rdx(input logic [11:0] a, input logic [31:0] x);
      i_host.xfer(1'b0, a, 32'h0, rd, e);
      chk(rd, x);
   endtask

   task automatic run(input int op, input int cnt, input logic [31:0] a);
      logic [63:0] w;
      logic [31:0] r;
      logic [31:0] v;
      int          i;
      wr(12'h000, a);
      wr(12'h004, {18'h0, cnt[5:0], 5'h0, op[2:0]});
      rd = 32'h10;
      // conversion to bcd runs for many cycles; poll busy under a bound
      for (i = 0; i < 60 && rd[4] !== 1'b0; i++) i_host.xfer(1'b0, 12'h008, 32'h0, rd, e);
      r = a;
      case (op)
         1: begin
            w = {a, a} >> (cnt % 32);
            r = w[31:0];
         end
         2: begin
            r = 0;
            for (i = 31; i >= 0; i--) if (a[i]) r = i;
            m_flg[2] = $countones(a) > 1;
            m_stat[1] = m_stat[1] | m_flg[2];
         end
         3: begin
            for (v = a; v > 31; v = v / 32) ;
            r = 32'h1 << v;
         end
         4: begin
            r = 0;
            m_flg[3] = 1'b0;
            for (i = 7; i >= 0; i--) begin
               r = r * 10 + a[4*i+:4];
               if (a[4*i+:4] > 9) m_flg[3] = 1'b1;
            end
            m_stat[2] = m_stat[2] | m_flg[3];
         end
         5: begin
            v = a % 100000000;
            for (i = 0; i < 8; i++) begin
               r[4*i+:4] = 4'(v % 10);
               v = v / 10;
            end
         end
         6: r = ~a;
         default: r = a;
      endcase
      if (op == 1 || op == 4 || op == 5) m_flg[1:0] = {r[31], r == 0};
      m_stat[0] = 1'b1;
      rdx(12'h000, r);
      rdx(12'h008, {28'h0, m_flg});
      rdx(12'h00c, {29'h0, m_stat});
   endtask

   initial begin
      #500000;
      err_total++;
      print_verdict();
   end

   initial begin
      void'($urandom(32'hadfe9f9a));
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      rdx(12'h000, 32'h0);
      rdx(12'h008, 32'h0);
      i_host.xfer(1'b0, 12'h020, 32'h0, rd, e);
      chk({31'h0, e}, 32'h1);
      chk(rd, 32'h0);
      wr(12'h010, 32'h2);
      run(2, 0, 32'h0000_0050);
      chk({31'h0, irq}, 32'h1);
      wr(12'h00c, 32'h1);
      m_stat[0] = 1'b0;
      chk({31'h0, irq}, 32'h1);
      wr(12'h00c, 32'h2);
      m_stat[1] = 1'b0;
      chk({31'h0, irq}, 32'h0);
      run(6, 0, 32'h0);
      chk({31'h0, irq}, 32'h0);
      run(1, 2, 32'h3);
      run(1, 32, 32'h1234_5678);
      run(1, 1, 32'h1);
      run(2, 0, 32'h8000_0000);
      run(2, 0, 32'h0);
      run(2, 0, 32'h1);
      run(3, 0, 32'hf);
      run(3, 0, 32'h1f);
      run(3, 0, 32'h2000);
      run(4, 0, 32'h1234_5678);
      run(4, 0, 32'h1a);
      run(4, 0, 32'h0);
      run(5, 0, 32'hffff_ffff);
      run(6, 0, 32'hffff_ffff);
      run(0, 0, 32'h5);
      run(7, 0, 32'h5);
      // enable low over a read's setup edge and early access phase: conversion frozen, an access-phase edge still captures
      wr(12'h000, 32'd12345678);
      wr(12'h004, 32'h5);
      ce <= 1'b0;
      fork
         begin
            repeat (40) @(posedge clk);
            ce <= 1'b1;
         end
      join_none
      i_host.xfer(1'b0, 12'h008, 32'h0, rd, e);
      chk({31'h0, rd[4]}, 32'h1);
      while (rd[4] !== 1'b0) i_host.xfer(1'b0, 12'h008, 32'h0, rd, e);
      m_flg[1:0] = 2'b00;
      m_stat[0] = 1'b1;
      rdx(12'h000, 32'h1234_5678);
      rdx(12'h008, {28'h0, m_flg});
      repeat (24) run(1 + $urandom % 6, 1 + $urandom % 32, $urandom);
      print_verdict();
   end
endmodule
`default_nettype wire

// file: hdl/abcu_pkg.sv
// types shared by the accumulator bit/convert unit
`default_nettype none
package abcu_pkg;
   typedef enum logic [0:0] {
      ABCU_IDLE    = 1'b0,
      ABCU_BCD_RUN = 1'b1
   } abcu_state_t;

   typedef enum logic [2:0] {
      ABCU_OP_NONE            = 3'h0,
      ABCU_OP_ROTATE_RIGHT    = 3'h1,
      ABCU_OP_PRIORITY_ENCODE = 3'h2,
      ABCU_OP_ONE_HOT_DECODE  = 3'h3,
      ABCU_OP_TO_BINARY       = 3'h4,
      ABCU_OP_TO_BCD          = 3'h5,
      ABCU_OP_ONES_COMPLEMENT = 3'h6
   } abcu_op_t;

   typedef struct packed {
      abcu_state_t state;
      logic [31:0] acc;
      logic        zero_result_flag;
      logic        negative_result_flag;
      logic        encode_overflow_flag;
      logic        invalid_digit_flag;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      logic [31:0] bcd_work;
      logic [31:0] bin_work;
      logic [5:0]  bcd_count;
      logic [31:0] prdata;
      logic        pslverr;
      logic        setup_done;
   } abcu_st_t;
endpackage
`default_nettype wire

// file: hdl/abcu_regs.svh
// register offsets, field positions and reset values of the accumulator bit/convert unit
`ifndef ABCU_REGS_SVH
`define ABCU_REGS_SVH
`define ABCU_OFF_ACC        12'h000
`define ABCU_OFF_CMD        12'h004
`define ABCU_OFF_FLAGS      12'h008
`define ABCU_OFF_IRQ_STAT   12'h00c
`define ABCU_OFF_IRQ_MASK   12'h010
`define ABCU_CMD_OP_LSB     0
`define ABCU_CMD_OP_MSB     2
`define ABCU_CMD_CNT_LSB    8
`define ABCU_CMD_CNT_MSB    13
`define ABCU_FLG_ZERO       0
`define ABCU_FLG_NEG        1
`define ABCU_FLG_ENC_OVF    2
`define ABCU_FLG_INV_DIG    3
`define ABCU_FLG_BUSY       4
`define ABCU_IRQ_DONE       0
`define ABCU_IRQ_ENC_OVF    1
`define ABCU_IRQ_INV_DIG    2
`define ABCU_RST_ACC        32'h0000_0000
`define ABCU_RST_FLAGS      4'h0
`define ABCU_RST_IRQ        3'h0
`define ABCU_BCD_CYCLES     6'h20
`endif

// file: hdl/abcu_unit.sv
// accumulator bit-operation and number-conversion unit with apb register access
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "abcu_regs.svh"
module abcu_unit #(
   parameter int ACC_W = 32
) (
   input  wire logic        clk,
   input  wire logic        reset_n,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic             irq
);
   // digit, rotate and encode logic assume exactly eight nibbles
   if (ACC_W != 32) begin : g_width_check
      $error("abcu_unit supports only a 32-bit accumulator");
   end

   abcu_pkg::abcu_st_t st_reg;
   abcu_pkg::abcu_st_t st_next;

   // lowest set bit index; overflow when more than one bit is set
   function automatic logic [5:0] enc_fn(input logic [31:0] v);
      logic [4:0] idx;
      logic       found;
      idx = 5'h00;
      found = 1'b0;
      for (int i = 0; i < 32; i++) begin
         if (v[i] && !found) begin
            idx = 5'(i);
            found = 1'b1;
         end
      end
      enc_fn = {(v & (v - 32'h0000_0001)) != 32'h0000_0000, idx};
   endfunction

   // repeated divide by 32 then one-hot; seven steps reduce any 32-bit value
   function automatic logic [31:0] dec_fn(input logic [31:0] v);
      logic [31:0] r;
      r = v;
      for (int i = 0; i < 7; i++) begin
         if (r > 32'h0000_001f) begin
            r = r >> 5;
         end
      end
      dec_fn = 32'h0000_0001 << r[4:0];
   endfunction

   // packed bcd to binary; top bit flags a digit above nine
   function automatic logic [32:0] bin_fn(input logic [31:0] v);
      logic [31:0] r;
      logic        bad;
      logic [3:0]  d;
      r = 32'h0000_0000;
      bad = 1'b0;
      d = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         d = v[i*4 +: 4];
         if (d > 4'h9) begin
            bad = 1'b1;
         end
         r = 32'(r * 32'd10) + {28'h0, d};
      end
      bin_fn = {bad, r};
   endfunction

   // one double-dabble step: adjust digits then shift in next binary bit
   function automatic logic [31:0] dabble_fn(input logic [31:0] b, input logic bit_in);
      logic [31:0] r;
      r = b;
      for (int i = 0; i < 8; i++) begin
         if (r[i*4 +: 4] > 4'h4) begin
            r[i*4 +: 4] = 4'(r[i*4 +: 4] + 4'h3);
         end
      end
      dabble_fn = {r[30:0], bit_in};
   endfunction

   // register select on a full word address; unaligned offsets never match
   function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
      reg_hit = (a == off);
   endfunction

   // offsets that answer; anything else reads zero with an error response
   function automatic logic reg_mapped(input logic [11:0] a);
      reg_mapped = reg_hit(a, `ABCU_OFF_ACC) || reg_hit(a, `ABCU_OFF_CMD) || reg_hit(a, `ABCU_OFF_FLAGS)
                   || reg_hit(a, `ABCU_OFF_IRQ_STAT) || reg_hit(a, `ABCU_OFF_IRQ_MASK);
   endfunction

   // read word of the addressed register; the command register and holes read as zero
   function automatic logic [31:0] rd_fn(input logic [11:0] a,
                                         input logic [31:0] acc,
                                         input logic [4:0]  flg,
                                         input logic [2:0]  stat,
                                         input logic [2:0]  mask);
      case (a)
         `ABCU_OFF_ACC:      rd_fn = acc;
         `ABCU_OFF_FLAGS:    rd_fn = {27'h0, flg};
         `ABCU_OFF_IRQ_STAT: rd_fn = {29'h0, stat};
         `ABCU_OFF_IRQ_MASK: rd_fn = {29'h0, mask};
         default:            rd_fn = 32'h0000_0000;
      endcase
   endfunction

   logic        setup_ph;
   logic        access_ph;
   logic        rd_capture;
   logic        xfer_done;
   logic        access_ok;
   logic        wr_acc;
   logic        wr_cmd;
   logic        wr_stat;
   logic        wr_mask;
   logic        busy;
   logic [2:0]  cmd_op;
   logic [5:0]  cmd_cnt;
   logic [5:0]  enc_res;
   logic [32:0] bin_res;
   logic [31:0] dec_res;
   logic [31:0] inv_res;
   logic [31:0] rot_res;
   logic [31:0] rot_stage [0:5];
   logic [4:0]  flags_word;
   logic [2:0]  irq_pend;
   logic [31:0] result;

   // a setup edge lost to a low enable is made up in the access phase,
   // so read data always comes from an edge that saw this transfer's address
   assign setup_ph   = psel && !penable;
   assign access_ph  = psel && penable;
   assign rd_capture = setup_ph || (access_ph && !st_reg.setup_done);
   assign xfer_done  = access_ph && st_reg.setup_done;
   assign pready     = ce && (!access_ph || st_reg.setup_done);
   assign access_ok  = xfer_done && pwrite;
   assign wr_acc     = access_ok && reg_hit(paddr, `ABCU_OFF_ACC);
   assign wr_cmd     = access_ok && reg_hit(paddr, `ABCU_OFF_CMD);
   assign wr_stat    = access_ok && reg_hit(paddr, `ABCU_OFF_IRQ_STAT);
   assign wr_mask    = access_ok && reg_hit(paddr, `ABCU_OFF_IRQ_MASK);
   assign prdata     = st_reg.prdata;
   assign pslverr    = st_reg.pslverr;
   assign irq_pend   = st_reg.irq_stat & st_reg.irq_mask;
   assign irq        = |irq_pend;
   assign busy       = (st_reg.state == abcu_pkg::ABCU_BCD_RUN);
   assign flags_word = {busy,
                        st_reg.invalid_digit_flag,
                        st_reg.encode_overflow_flag,
                        st_reg.negative_result_flag,
                        st_reg.zero_result_flag};
   assign cmd_op     = pwdata[`ABCU_CMD_OP_MSB:`ABCU_CMD_OP_LSB];
   assign cmd_cnt    = pwdata[`ABCU_CMD_CNT_MSB:`ABCU_CMD_CNT_LSB];
   assign enc_res    = enc_fn(st_reg.acc);
   assign bin_res    = bin_fn(st_reg.acc);
   assign dec_res    = dec_fn(st_reg.acc);
   assign inv_res    = ~st_reg.acc;

   // five-stage rotator; a count of 32 has zero low bits and passes straight through
   assign rot_stage[0] = st_reg.acc;
   for (genvar s = 0; s < 5; s++) begin : g_rot
      assign rot_stage[s+1] = cmd_cnt[s] ? {rot_stage[s][(2**s)-1:0], rot_stage[s][31:2**s]}
                                         : rot_stage[s];
   end
   assign rot_res = rot_stage[5];

   always_comb begin
      logic [2:0] ev;
      logic       upd_zn;
      ev = 3'h0;
      upd_zn = 1'b0;
      result = st_reg.acc;
      st_next = st_reg;
      // the completion edge closes the transfer; any other edge with psel high has seen the address
      st_next.setup_done = psel && !xfer_done;
      // read data held from the capture edge through the access phase
      if (rd_capture) begin
         st_next.prdata = rd_fn(paddr, st_reg.acc, flags_word, st_reg.irq_stat, st_reg.irq_mask);
         st_next.pslverr = !reg_mapped(paddr);
      end
      if (wr_mask) begin
         st_next.irq_mask = pwdata[2:0];
      end
      case (st_reg.state)
         abcu_pkg::ABCU_IDLE: begin
            if (wr_acc) begin
               st_next.acc = pwdata;
            end else if (wr_cmd) begin
               case (abcu_pkg::abcu_op_t'(cmd_op))
                  abcu_pkg::ABCU_OP_ROTATE_RIGHT: begin
                     result = rot_res;
                     upd_zn = 1'b1;
                  end
                  abcu_pkg::ABCU_OP_PRIORITY_ENCODE: begin
                     result = {27'h0, enc_res[4:0]};
                     st_next.encode_overflow_flag = enc_res[5];
                     ev[`ABCU_IRQ_ENC_OVF] = enc_res[5];
                  end
                  abcu_pkg::ABCU_OP_ONE_HOT_DECODE: begin
                     result = dec_res;
                  end
                  abcu_pkg::ABCU_OP_TO_BINARY: begin
                     result = bin_res[31:0];
                     st_next.invalid_digit_flag = bin_res[32];
                     ev[`ABCU_IRQ_INV_DIG] = bin_res[32];
                     upd_zn = 1'b1;
                  end
                  abcu_pkg::ABCU_OP_TO_BCD: begin
                     // multi-cycle; only the low eight digits fit the accumulator
                     st_next.state = abcu_pkg::ABCU_BCD_RUN;
                     st_next.bin_work = st_reg.acc;
                     st_next.bcd_work = 32'h0000_0000;
                     st_next.bcd_count = `ABCU_BCD_CYCLES;
                  end
                  abcu_pkg::ABCU_OP_ONES_COMPLEMENT: begin
                     result = inv_res;
                  end
                  default: begin
                     result = st_reg.acc;
                  end
               endcase
               st_next.acc = result;
               if (abcu_pkg::abcu_op_t'(cmd_op) != abcu_pkg::ABCU_OP_TO_BCD) begin
                  ev[`ABCU_IRQ_DONE] = 1'b1;
               end
            end
         end
         abcu_pkg::ABCU_BCD_RUN: begin
            // acc and cmd writes are dropped while the conversion runs
            st_next.bcd_work = dabble_fn(st_reg.bcd_work, st_reg.bin_work[31]);
            st_next.bin_work = {st_reg.bin_work[30:0], 1'b0};
            st_next.bcd_count = 6'(st_reg.bcd_count - 6'h01);
            if (st_reg.bcd_count == 6'h01) begin
               result = st_next.bcd_work;
               st_next.acc = result;
               upd_zn = 1'b1;
               ev[`ABCU_IRQ_DONE] = 1'b1;
               st_next.state = abcu_pkg::ABCU_IDLE;
            end
         end
         default: begin
            st_next.state = abcu_pkg::ABCU_IDLE;
         end
      endcase
      if (upd_zn) begin
         st_next.zero_result_flag = (result == 32'h0000_0000);
         st_next.negative_result_flag = result[31];
      end
      // sticky events: a new event wins over a same-cycle clear
      if (wr_stat) begin
         st_next.irq_stat = st_reg.irq_stat & ~pwdata[2:0];
      end
      st_next.irq_stat = st_next.irq_stat | ev;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         st_reg.state <= abcu_pkg::ABCU_IDLE;
         st_reg.acc <= `ABCU_RST_ACC;
         {st_reg.zero_result_flag, st_reg.negative_result_flag,
          st_reg.encode_overflow_flag, st_reg.invalid_digit_flag} <= `ABCU_RST_FLAGS;
         st_reg.irq_stat <= `ABCU_RST_IRQ;
         st_reg.irq_mask <= `ABCU_RST_IRQ;
         st_reg.bcd_work <= 32'h0000_0000;
         st_reg.bin_work <= 32'h0000_0000;
         st_reg.bcd_count <= 6'h00;
         st_reg.prdata <= 32'h0000_0000;
         st_reg.pslverr <= 1'b0;
         st_reg.setup_done <= 1'b0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end
endmodule
`default_nettype wire
